// ### serial_port_stats.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "stats_map.svh"
module serial_port_stats #(
   parameter int NPORT = `PORT_NUM,
   parameter int CW = `CNT_WIDTH,
   parameter int FAULT_CYCLES = `FAULT_TIME_MS * `CLK_FREQ_KHZ,
   parameter logic [7:0] MAX_RETRY = `MAX_RETRY_RST
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // serial port side
   input wire stats_pkg::ev_t [NPORT-1:0] ev,
   input wire logic [NPORT-1:0] cts,
   output stats_pkg::resp_t [NPORT-1:0] resp,
   // fault indicators
   output logic fault_red,
   output logic fault_green
);

   typedef struct packed {
      logic [NPORT-1:0][`CNT_NUM-1:0][CW-1:0] cnt;
      logic [NPORT-1:0][7:0] limit;
      logic [NPORT-1:0][7:0] in_use;
      logic [NPORT-1:0][7:0] tries;
      logic [NPORT-1:0] cts_s1;
      logic [NPORT-1:0] cts_s2;
      stats_pkg::resp_t [NPORT-1:0] resp;
      logic [31:0] fault_tmr;
      logic fault;
      logic [31:0] rdata;
   } state_t;

   state_t q;
   state_t d;

   // next state of the whole block
   always_comb begin
      logic [`CNT_NUM-1:0] inc;
      logic [7:0] used;
      logic [7:0] avail;
      logic err;
      logic zero;
      inc = '0;
      used = '0;
      avail = '0;
      err = 1'b0;
      zero = 1'b0;
      d = q;
      d.rdata = '0;

      // every port runs the same bank; only the error flag feeding the fault lamp timer is shared
      for (int p = 0; p < NPORT; p++) begin
         inc = '0;
         d.resp[p] = '0;

         // cts is a pin: two flops before use
         d.cts_s1[p] = cts[p];
         d.cts_s2[p] = q.cts_s1[p];
         d.resp[p].tx_hold = ~q.cts_s2[p];

         // free buffers left under this port's limit
         used = q.in_use[p];
         avail = (q.limit[p] > used) ? 8'(q.limit[p] - used) : 8'h00;

         // receive side; receive takes a buffer before origination
         if (ev[p].rx_done) begin
            if (!ev[p].rx_good) begin
               d.resp[p].nak = 1'b1;
               inc[stats_pkg::cnt_rx_bad] = 1'b1;
            end else if (avail != 8'h00) begin
               d.resp[p].ack = 1'b1;
               inc[stats_pkg::cnt_rx_ok] = 1'b1;
               used = 8'(used + 8'h01);
               avail = 8'(avail - 8'h01);
            end else begin
               inc[stats_pkg::cnt_rx_lost] = 1'b1;
            end
         end

         // internally originated message
         if (ev[p].gen_req) begin
            inc[stats_pkg::cnt_gen_pkt] = 1'b1;
            if (avail != 8'h00) begin
               d.resp[p].gen_grant = 1'b1;
               used = 8'(used + 8'h01);
            end else begin
               inc[stats_pkg::cnt_gen_fail] = 1'b1;
            end
         end

         // outcome of one transmission attempt
         if (ev[p].tx_done) begin
            if (ev[p].tx_ack) begin
               inc[stats_pkg::cnt_tx_acked] = 1'b1;
               d.tries[p] = 8'h00;
            end else if (q.tries[p] < MAX_RETRY) begin
               d.resp[p].tx_retry = 1'b1;
               inc[stats_pkg::cnt_tx_retry] = 1'b1;
               d.tries[p] = 8'(q.tries[p] + 8'h01);
            end else begin
               d.resp[p].tx_drop = 1'b1;
               inc[stats_pkg::cnt_tx_fail] = 1'b1;
               d.tries[p] = 8'h00;
            end
         end

         // buffer returned by the port; never below zero
         if (ev[p].buf_release && used != 8'h00) begin
            used = 8'(used - 8'h01);
         end
         d.in_use[p] = used;

         // counts that follow their strobe one for one
         inc[stats_pkg::cnt_unroute] = ev[p].rx_unroutable;
         inc[stats_pkg::cnt_illegal] = ev[p].rx_illegal;
         inc[stats_pkg::cnt_prio_rd] = ev[p].prio_rd;
         inc[stats_pkg::cnt_prio_wr] = ev[p].prio_wr;
         inc[stats_pkg::cnt_norm_rd] = ev[p].norm_rd;
         inc[stats_pkg::cnt_norm_wr] = ev[p].norm_wr;
         inc[stats_pkg::cnt_char_err] = ev[p].char_err;
         inc[stats_pkg::cnt_tx_chars] = ev[p].tx_byte;
         inc[stats_pkg::cnt_rx_chars] = ev[p].rx_byte;

         // zero command; an event in the same cycle still counts
         zero = wr && (addr == `ZERO_ADDR) && wdata[p];
         for (int c = 0; c < `CNT_NUM; c++) begin
            d.cnt[p][c] = (zero ? '0 : q.cnt[p][c]) + CW'(inc[c]);
         end

         // buffer limit write
         if (wr && addr == 8'(`LIMIT_BASE + p)) begin
            d.limit[p] = wdata[7:0];
         end

         err = err | (|(inc & `ERR_MASK));
      end

      // fault lamp timer, retriggered by every error increment
      if (err) begin
         d.fault = 1'b1;
         d.fault_tmr = 32'(FAULT_CYCLES - 1);
      end else if (q.fault_tmr != 32'h0000_0000) begin
         d.fault_tmr = q.fault_tmr - 32'h0000_0001;
      end else begin
         d.fault = 1'b0;
      end

      // read decode; unmapped reads return zero
      if (rd) begin
         for (int p = 0; p < NPORT; p++) begin
            for (int c = 0; c < `CNT_NUM; c++) begin
               if (addr == 8'(`CNT_BASE + p * `PORT_STRIDE + c)) begin
                  d.rdata = 32'(q.cnt[p][c]);
               end
            end
            if (addr == 8'(`LIMIT_BASE + p)) begin
               d.rdata = {24'h00_0000, q.limit[p]};
            end
            if (addr == 8'(`STATUS_BASE + p)) begin
               d.rdata = {16'h0000, q.in_use[p], 7'h00, q.cts_s2[p]};
            end
         end
      end
   end

   // one register stage for all state
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         q <= '0;
         for (int p = 0; p < NPORT; p++) begin
            q.limit[p] <= `BUF_LIMIT_RST;
         end
      end else begin
         q <= d;
      end
   end

   // outputs straight from state flops
   assign rdata = q.rdata;
   assign resp = q.resp;
   assign fault_red = q.fault;
   assign fault_green = q.fault;

endmodule

// ### stats_map.svh
`ifndef STATS_MAP_SVH
`define STATS_MAP_SVH

// sizes
`define PORT_NUM 2
`define CNT_NUM 17
`define CNT_WIDTH 32

// register offsets
`define CNT_BASE 8'h00
`define PORT_STRIDE 8'h20
`define LIMIT_BASE 8'h40
`define ZERO_ADDR 8'h48
`define STATUS_BASE 8'h50

// reset values
`define BUF_LIMIT_RST 8'h10
`define MAX_RETRY_RST 8'h03

// counters whose increment lights the fault indicators
`define ERR_MASK 17'h0_43d6

// timing
`define CLK_FREQ_KHZ 100000
`define FAULT_TIME_MS 1000

`endif

// ### stats_pkg.sv
package stats_pkg;

   // counter slot within one port's bank
   typedef enum logic [4:0] {
      cnt_rx_ok,
      cnt_rx_lost,
      cnt_rx_bad,
      cnt_gen_pkt,
      cnt_gen_fail,
      cnt_tx_acked,
      cnt_tx_fail,
      cnt_tx_retry,
      cnt_unroute,
      cnt_illegal,
      cnt_prio_rd,
      cnt_prio_wr,
      cnt_norm_rd,
      cnt_norm_wr,
      cnt_char_err,
      cnt_tx_chars,
      cnt_rx_chars
   } cnt_idx_t;

   // event strobes from one port's protocol logic
   typedef struct packed {
      logic rx_done;
      logic rx_good;
      logic rx_unroutable;
      logic rx_illegal;
      logic prio_rd;
      logic prio_wr;
      logic norm_rd;
      logic norm_wr;
      logic char_err;
      logic rx_byte;
      logic tx_byte;
      logic gen_req;
      logic tx_done;
      logic tx_ack;
      logic buf_release;
   } ev_t;

   // answers to one port's protocol logic
   typedef struct packed {
      logic ack;
      logic nak;
      logic gen_grant;
      logic tx_retry;
      logic tx_drop;
      logic tx_hold;
   } resp_t;

endpackage

// ### serial_port_stats_chk.sv
`timescale 1ns/1ps
module serial_port_stats_chk #(
   parameter int NPORT = 2
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // port side and lamps
   input wire stats_pkg::ev_t [NPORT-1:0] ev,
   input wire logic [NPORT-1:0] cts,
   input wire stats_pkg::resp_t [NPORT-1:0] resp,
   input wire logic fault_red,
   input wire logic fault_green
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // answers one cycle after their cause
   a_nak_bad: assert property (ev[0].rx_done && !ev[0].rx_good |=> resp[0].nak)
      else $error("nak missing");
   a_ack_cause: assert property (resp[0].ack |-> $past(ev[0].rx_good))
      else $error("ack without good packet");
   a_port1_nak: assert property (ev[1].rx_done && !ev[1].rx_good |=> resp[1].nak)
      else $error("port 1 nak missing");
   a_retry_nak: assert property (ev[0].tx_done && !ev[0].tx_ack |=>
      resp[0].tx_retry != resp[0].tx_drop)
      else $error("no retry or drop");
   // lamps: both alike, lit a long while
   a_lamps_same: assert property (fault_red == fault_green)
      else $error("lamps differ");
   a_err_lamp: assert property ((ev[0].rx_done && !ev[0].rx_good) || ev[1].char_err |=> fault_red)
      else $error("lamp not lit");
   a_lamp_hold: assert property ($rose(fault_red) |-> fault_red [*8])
      else $error("lamp too short");
   // sync latency of three edges
   a_hold_cts: assert property (!cts[0] [*4] |-> resp[0].tx_hold)
      else $error("no hold");
endmodule

bind serial_port_stats serial_port_stats_chk #(.NPORT(NPORT)) chk (.sys_clk(sys_clk),
   .resetn(resetn), .ev(ev), .cts(cts), .resp(resp), .fault_red(fault_red),
   .fault_green(fault_green));

// ### ser_dev.sv
`timescale 1ns/1ps
module ser_dev (
   // clock
   input wire logic sys_clk,
   // frame requests in, strobes out
   input wire stats_pkg::ev_t [1:0] req,
   output stats_pkg::ev_t [1:0] ev
);
   // registered so strobes move just after an edge
   always_ff @(posedge sys_clk) begin
      ev <= req;
   end
endmodule

// ### serial_port_stats_bench.sv
`timescale 1ns/1ps
module serial_port_stats_bench;
   logic sys_clk = 0;
   logic resetn = 0;
   logic [7:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr = 0;
   logic rd = 0;
   logic [31:0] rdata;
   stats_pkg::ev_t [1:0] req = '0;
   stats_pkg::ev_t [1:0] ev;
   logic [1:0] cts = 2'h3;
   stats_pkg::resp_t [1:0] resp;
   logic fault_red;
   logic fault_green;
   int failures = 0;
   int n_compared = 0;
   always #5 sys_clk = ~sys_clk;
   ser_dev dev (.sys_clk(sys_clk), .req(req), .ev(ev));
   // short lamp time keeps the run brief
   serial_port_stats #(.FAULT_CYCLES(20)) uut (.sys_clk(sys_clk), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ev(ev), .cts(cts),
      .resp(resp), .fault_red(fault_red), .fault_green(fault_green));
   task results();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
         failures++;
      end
   endtask
   // bus cycles, strobes one cycle long
   task rd_chk(input logic [7:0] a, input logic [31:0] x);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1;
      @(posedge sys_clk);
      rd <= 0;
      #1 cmp(rdata, x);
   endtask
   task wr_go(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge sys_clk);
      wr <= 0;
   endtask
   // one frame from the far side, then let answers settle
   task fire(input int p, input stats_pkg::ev_t e);
      @(posedge sys_clk);
      req[p] <= e;
      @(posedge sys_clk);
      req[p] <= '0;
      repeat (3) @(posedge sys_clk);
   endtask
   task t_rx();
      rd_chk(8'h40, 32'h10);
      rd_chk(8'h00, 32'h0);
      fire(0, 15'h6000);
      fire(0, 15'h4000);
      cmp(fault_red, 32'h1);
      fire(1, 15'h4000);
      rd_chk(8'h00, 32'h1);
      rd_chk(8'h02, 32'h1);
      rd_chk(8'h20, 32'h0);
      repeat (25) @(posedge sys_clk);
      cmp(fault_green, 32'h0);
   endtask
   // one buffer already taken, so a limit of one is full
   task t_buf();
      wr_go(8'h40, 32'h1);
      fire(0, 15'h6000);
      fire(0, 15'h0008);
      fire(0, 15'h0001);
      fire(0, 15'h0008);
      rd_chk(8'h01, 32'h1);
      rd_chk(8'h04, 32'h1);
      rd_chk(8'h03, 32'h2);
      rd_chk(8'h50, 32'h0000_0101);
      rd_chk(8'h48, 32'h0);
   endtask
   // three retries allowed, the fourth failure drops
   task t_tx();
      for (int i = 0; i < 4; i++) fire(0, 15'h0004);
      fire(0, 15'h0006);
      rd_chk(8'h07, 32'h3);
      rd_chk(8'h06, 32'h1);
      rd_chk(8'h05, 32'h1);
   endtask
   // strobe bit of each remaining counter slot
   task t_misc();
      int b;
      for (int i = 8; i < 17; i++) begin
         b = (i == 16) ? 5 : (i == 15) ? 4 : 20 - i;
         fire(1, stats_pkg::ev_t'(15'h1 << b));
         rd_chk(8'h20 + 8'(i), 32'h1);
      end
   endtask
   task t_zero();
      wr_go(8'h48, 32'h1);
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h07, 32'h0);
      rd_chk(8'h22, 32'h1);
   endtask
   task t_cts();
      @(posedge sys_clk);
      cts[0] <= 0;
      repeat (5) @(posedge sys_clk);
      cmp(resp[0].tx_hold, 32'h1);
      cts[0] <= 1;
      repeat (5) @(posedge sys_clk);
      cmp(resp[0].tx_hold, 32'h0);
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      resetn <= 1;
      t_rx();
      t_buf();
      t_tx();
      t_misc();
      t_zero();
      t_cts();
      results();
   end
   // hang guard
   initial begin
      #1000000;
      failures++;
      results();
   end
endmodule
